/* rtl/cidc_pkg.sv */
// constants shared by the coprocessor instruction decode front end
`default_nettype none
package cidc_pkg;
    // ************************************************************
    // register map (byte addresses on the apb)
    // ************************************************************
    localparam logic [7:0] ADDR_MSC = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;
    localparam logic [7:0] ADDR_STATE = 8'h10;
    localparam logic [7:0] ADDR_TABLE = 8'h20;
    localparam logic [7:0] ADDR_TABLE_END = 8'h3c;

    // ************************************************************
    // machine_state_control fields and reset
    // ************************************************************
    localparam int MSC_COPROC_PRESENT = 6;
    localparam int MSC_EXC_ENABLE = 12;
    localparam int MSC_FPU_PRESENT = 18;
    localparam int MSC_FP_EXC_MODE_HI = 20;
    localparam int MSC_FP_EXC_MODE_LO = 23;
    localparam logic [31:0] MSC_RESET = 32'h0000_0000;

    // ************************************************************
    // control register fields and reset
    // ************************************************************
    localparam int CTRL_FABRIC_CLASS_LSB = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

    // ************************************************************
    // status / mask bits
    // ************************************************************
    localparam int ST_BIT_DONE = 0;
    localparam int ST_BIT_ILLEGAL = 1;
    localparam int ST_BIT_EXC = 2;
    localparam int ST_BIT_FLUSH = 3;
    localparam int STATUS_W = 4;

    // ************************************************************
    // instruction fields and opcodes
    // ************************************************************
    localparam logic [5:0] OP_PRIM_CUSTOM0 = 6'h00;
    localparam logic [5:0] OP_PRIM_CUSTOM4 = 6'h04;
    localparam logic [5:0] OP_PRIM_FP_SINGLE = 6'h3b;
    localparam logic [5:0] OP_PRIM_FP_DOUBLE = 6'h3f;
    localparam logic [11:0] OP_EXT_ILLEGAL = 12'h000;
    localparam logic [6:0] OP_EXT_CUSTOM_CR = 7'h46;
    localparam logic [31:0] EXC_VECTOR = 32'h0000_0700;

    // ************************************************************
    // custom table entry layout
    // ************************************************************
    localparam int CUSTOM_SLOTS = 8;
    localparam int TBL_PRIM_LSB = 0;
    localparam int TBL_EXT_LSB = 6;
    localparam int TBL_VALID = 17;
    localparam int TBL_CLASS_LSB = 18;
    localparam int TBL_SETS_CR = 20;
    localparam int KEY_W = 17;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        CIDC_CLS_AUTO = 2'h0,
        CIDC_CLS_BLOCK = 2'h1,
        CIDC_CLS_NONBLOCK = 2'h2
    } cidc_class_t;

    typedef enum logic [2:0] {
        CIDC_K_NONE,
        CIDC_K_ILLEGAL,
        CIDC_K_FP,
        CIDC_K_CUSTOM,
        CIDC_K_CUSTOM_CR
    } cidc_kind_t;
endpackage
`default_nettype wire

/* rtl/cidc_custom_table.sv */
// configured custom instruction table with registered readback and lookup
`default_nettype none
module cidc_custom_table
    import cidc_pkg::*;
#(
    parameter int SLOTS = CUSTOM_SLOTS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [$clog2(SLOTS)-1:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [$clog2(SLOTS)-1:0] rd_idx,
    output logic [31:0] rd_data_r,
    input wire logic [KEY_W-1:0] key,
    output logic hit_r,
    output logic [$clog2(SLOTS)-1:0] hit_idx_r,
    output logic [31:0] hit_cfg_r
);
    logic [31:0] mem_r [SLOTS];
    logic hit_nxt;
    logic [$clog2(SLOTS)-1:0] hit_idx_nxt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < SLOTS; i++) begin
                mem_r[i] <= 32'h0000_0000;
            end
        end else if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_r <= 32'h0000_0000;
        end else begin
            rd_data_r <= mem_r[rd_idx];
        end
    end

    // lowest matching slot wins so a duplicate entry is harmless
    always_comb begin
        hit_nxt = 1'b0;
        hit_idx_nxt = '0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (mem_r[i][TBL_VALID] && mem_r[i][TBL_EXT_LSB+10:TBL_PRIM_LSB] == key) begin
                hit_nxt = 1'b1;
                hit_idx_nxt = i[$clog2(SLOTS)-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_r <= 1'b0;
            hit_idx_r <= '0;
            hit_cfg_r <= 32'h0000_0000;
        end else begin
            hit_r <= hit_nxt;
            hit_idx_r <= hit_idx_nxt;
            hit_cfg_r <= mem_r[hit_idx_nxt];
        end
    end
endmodule
`default_nettype wire

/* rtl/cidc_decode_top.sv */
// coprocessor instruction decode and class control with apb registers
//
// Summary of operation
// - no coprocessor instruction is accepted before machine state is written
// - machine state bit 6 reads one when the coprocessor path exists
// - machine state bit 12 enables taking coprocessor exceptions
// - machine state bit 18 reads one when a float unit exists
// - bits 20 and 23 hold the float exception mode pair
// - autonomous instructions never stall the core and return nothing
// - next coprocessor instruction waits while an autonomous one is busy
// - non-autonomous instructions stall the core until the coprocessor is done
// - interrupts and exceptions are held off during a blocking instruction
// - non-blocking instructions may be aborted, serviced and issued again
// - primary and extended opcodes together identify each instruction
// - predefined instructions use source and target fields as registers
// - primary 0 with zero extended opcode is illegal, else custom
// - primary 4: reserved half, one condition-setting pattern, rest custom
// - primaries 59 and 63 are predefined float instructions
// - decoder covers hard-coded predefined and a few configured customs
// - an enabled coprocessor exception during a non-autonomous instruction flushes and vectors to 0x700
//
// Design decisions made here: the APB register port and the register offsets.
`default_nettype none
module cidc_decode_top
    import cidc_pkg::*;
#(
    parameter logic HAS_COPROC = 1'b1,
    parameter logic HAS_FPU = 1'b1,
    parameter int SLOTS = CUSTOM_SLOTS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic core_issue,
    input wire logic [31:0] core_instr,
    input wire logic core_abort,
    output logic core_ready,
    output logic core_stall,
    output logic core_irq_hold,
    output logic core_illegal,
    output logic core_result_valid,
    output logic [31:0] core_result,
    output logic core_exc_req,
    output logic [31:0] core_exc_vector,
    output logic coproc_issue,
    output logic [31:0] coproc_instr,
    output logic [1:0] coproc_class,
    output logic coproc_is_fp,
    output logic coproc_sets_cr,
    output logic coproc_fields_are_regs,
    output logic coproc_custom_hit,
    output logic [$clog2(SLOTS)-1:0] coproc_custom_idx,
    output logic coproc_flush,
    input wire logic coproc_done,
    input wire logic [31:0] coproc_result,
    input wire logic coproc_exception
);
    localparam int IW = $clog2(SLOTS);

    typedef enum logic [1:0] {CIDC_IDLE, CIDC_LOOKUP, CIDC_WAIT} cidc_state_t;

    // ************************************************************
    // opcode classification
    // ************************************************************
    function automatic cidc_kind_t cidc_kind(input logic [31:0] ins, input logic fpu_on);
        logic [5:0] prim;
        prim = ins[31:26];
        cidc_kind = CIDC_K_NONE;
        if (prim == OP_PRIM_CUSTOM0) begin
            cidc_kind = (ins[11:0] == OP_EXT_ILLEGAL) ? CIDC_K_ILLEGAL : CIDC_K_CUSTOM;
        end else if (prim == OP_PRIM_CUSTOM4) begin
            if (!ins[6]) begin
                cidc_kind = CIDC_K_NONE;
            end else if (ins[6:0] == OP_EXT_CUSTOM_CR) begin
                cidc_kind = CIDC_K_CUSTOM_CR;
            end else begin
                cidc_kind = CIDC_K_CUSTOM;
            end
        end else if ((prim == OP_PRIM_FP_SINGLE || prim == OP_PRIM_FP_DOUBLE) && fpu_on) begin
            cidc_kind = CIDC_K_FP;
        end
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    cidc_state_t state_r, state_nxt;
    logic [31:0] msc_r;
    logic [31:0] ctrl_r;
    logic [STATUS_W-1:0] status_r;
    logic [STATUS_W-1:0] mask_r;
    logic configured_r;
    logic auto_pend_r, auto_pend_nxt;
    logic [31:0] instr_r;
    logic [1:0] class_r, class_nxt;
    logic [31:0] prdata_nxt;
    logic slverr_nxt;
    logic wr_en;
    logic acc;
    logic in_table;
    logic [31:0] msc_view;
    logic tbl_hit;
    logic [IW-1:0] tbl_idx;
    logic [31:0] tbl_cfg;
    logic [31:0] tbl_rd;
    cidc_kind_t kind;
    logic issue_nxt, illegal_nxt, flush_nxt, exc_nxt, done_nxt;
    logic take;

    assign acc = psel && penable && !pready;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign in_table = paddr >= ADDR_TABLE && paddr <= ADDR_TABLE_END && paddr[1:0] == 2'b00;
    assign kind = cidc_kind(instr_r, HAS_FPU);
    assign take = core_issue && core_ready;

    // presence bits come from the build, not from software
    always_comb begin
        msc_view = msc_r;
        msc_view[MSC_COPROC_PRESENT] = HAS_COPROC;
        msc_view[MSC_FPU_PRESENT] = HAS_FPU;
    end

    // configured custom slots beside the hard-coded decode
    cidc_custom_table #(.SLOTS(SLOTS)) u_table (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_en && in_table),
        .wr_idx(paddr[IW+1:2]),
        .wr_data(pwdata),
        .rd_idx(paddr[IW+1:2]),
        .rd_data_r(tbl_rd),
        .key({core_instr[10:0], core_instr[31:26]}),
        .hit_r(tbl_hit),
        .hit_idx_r(tbl_idx),
        .hit_cfg_r(tbl_cfg)
    );

    // ************************************************************
    // apb slave: one wait state so table reads come from a register
    // ************************************************************
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        slverr_nxt = 1'b0;
        if (in_table) begin
            prdata_nxt = tbl_rd;
        end else begin
            case (paddr)
                ADDR_MSC: prdata_nxt = msc_view;
                ADDR_CTRL: prdata_nxt = ctrl_r;
                ADDR_STATUS: prdata_nxt = {28'h0000000, status_r};
                ADDR_MASK: prdata_nxt = {28'h0000000, mask_r};
                ADDR_STATE: prdata_nxt = {28'h0000000, auto_pend_r, configured_r, state_r};
                default: slverr_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= acc;
            pslverr <= acc && slverr_nxt;
            prdata <= (acc && !pwrite) ? prdata_nxt : 32'h0000_0000;
        end
    end

    // exception enable kept in software-written bit
    // float exception mode pair stored as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msc_r <= MSC_RESET;
        end else if (wr_en && paddr == ADDR_MSC) begin
            msc_r <= pwdata;
        end
    end

    // path unusable until machine state has been written once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            configured_r <= 1'b0;
        end else if (wr_en && paddr == ADDR_MSC) begin
            configured_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
            mask_r <= '0;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl_r <= {30'h00000000, pwdata[CTRL_FABRIC_CLASS_LSB+1:CTRL_FABRIC_CLASS_LSB]};
        end else if (wr_en && paddr == ADDR_MASK) begin
            mask_r <= pwdata[STATUS_W-1:0];
        end
    end

    // sticky events; a new event in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~((wr_en && paddr == ADDR_STATUS) ?
                        pwdata[STATUS_W-1:0] : {STATUS_W{1'b0}}))
                        | {flush_nxt, exc_nxt, illegal_nxt, done_nxt};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    // ************************************************************
    // decode and class sequencing
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        auto_pend_nxt = auto_pend_r;
        class_nxt = class_r;
        issue_nxt = 1'b0;
        illegal_nxt = 1'b0;
        flush_nxt = 1'b0;
        exc_nxt = 1'b0;
        done_nxt = 1'b0;
        // autonomous work ends on the coprocessor's done
        if (auto_pend_r && coproc_done && state_r != CIDC_WAIT) begin
            auto_pend_nxt = 1'b0;
            done_nxt = 1'b1;
        end
        case (state_r)
            CIDC_IDLE: begin
                if (take) begin
                    state_nxt = CIDC_LOOKUP;
                end
            end
            CIDC_LOOKUP: begin
                state_nxt = CIDC_IDLE;
                // primary plus extended decides the kind
                if (!configured_r || !HAS_COPROC || kind == CIDC_K_NONE
                    || kind == CIDC_K_ILLEGAL) begin
                    illegal_nxt = 1'b1;
                end else begin
                    issue_nxt = 1'b1;
                    if (kind == CIDC_K_FP) begin
                        class_nxt = CIDC_CLS_NONBLOCK;
                    // unmatched custom goes to the fabric with default class
                    end else if (tbl_hit) begin
                        class_nxt = tbl_cfg[TBL_CLASS_LSB+1:TBL_CLASS_LSB];
                    end else begin
                        class_nxt = ctrl_r[CTRL_FABRIC_CLASS_LSB+1:CTRL_FABRIC_CLASS_LSB];
                    end
                    if (class_nxt == CIDC_CLS_AUTO) begin
                        auto_pend_nxt = 1'b1;
                    end else begin
                        state_nxt = CIDC_WAIT;
                    end
                end
            end
            CIDC_WAIT: begin
                if (coproc_done) begin
                    done_nxt = 1'b1;
                    state_nxt = CIDC_IDLE;
                end else if (coproc_exception && msc_r[MSC_EXC_ENABLE]) begin
                    exc_nxt = 1'b1;
                    flush_nxt = 1'b1;
                    state_nxt = CIDC_IDLE;
                end else if (core_abort && class_r == CIDC_CLS_NONBLOCK) begin
                    flush_nxt = 1'b1;
                    state_nxt = CIDC_IDLE;
                end
            end
            default: state_nxt = CIDC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= CIDC_IDLE;
            auto_pend_r <= 1'b0;
            class_r <= CIDC_CLS_AUTO;
            instr_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            auto_pend_r <= auto_pend_nxt;
            class_r <= class_nxt;
            if (take) begin
                instr_r <= core_instr;
            end
        end
    end

    // ************************************************************
    // core-side outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ready <= 1'b0;
            core_stall <= 1'b0;
            core_irq_hold <= 1'b0;
            core_illegal <= 1'b0;
            core_exc_req <= 1'b0;
            core_exc_vector <= 32'h0000_0000;
        end else begin
            // hold back while autonomous work is pending
            core_ready <= state_nxt == CIDC_IDLE && !auto_pend_nxt && !take;
            // stall for the whole non-autonomous wait
            core_stall <= state_nxt == CIDC_WAIT;
            core_irq_hold <= state_nxt == CIDC_WAIT && class_nxt == CIDC_CLS_BLOCK;
            core_illegal <= illegal_nxt;
            core_exc_req <= exc_nxt;
            core_exc_vector <= EXC_VECTOR;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_result_valid <= 1'b0;
            core_result <= 32'h0000_0000;
        end else begin
            core_result_valid <= state_r == CIDC_WAIT && coproc_done;
            if (state_r == CIDC_WAIT && coproc_done) begin
                core_result <= coproc_result;
            end
        end
    end

    // ************************************************************
    // coprocessor-side outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coproc_issue <= 1'b0;
            coproc_instr <= 32'h0000_0000;
            coproc_class <= CIDC_CLS_AUTO;
            coproc_is_fp <= 1'b0;
            coproc_sets_cr <= 1'b0;
            coproc_fields_are_regs <= 1'b0;
            coproc_custom_hit <= 1'b0;
            coproc_custom_idx <= '0;
            coproc_flush <= 1'b0;
        end else begin
            coproc_issue <= issue_nxt;
            coproc_flush <= flush_nxt;
            if (issue_nxt) begin
                coproc_instr <= instr_r;
                coproc_class <= class_nxt;
                coproc_is_fp <= kind == CIDC_K_FP;
                coproc_sets_cr <= kind == CIDC_K_CUSTOM_CR ||
                                  (kind != CIDC_K_FP && tbl_hit && tbl_cfg[TBL_SETS_CR]);
                coproc_fields_are_regs <= kind == CIDC_K_FP;
                coproc_custom_hit <= kind != CIDC_K_FP && tbl_hit;
                coproc_custom_idx <= tbl_idx;
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/cidc_decode_top_asserts.sv */
// assertion checker for the coprocessor decode front end
`default_nettype none
module cidc_decode_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_abort,
    input wire logic core_stall,
    input wire logic core_irq_hold,
    input wire logic core_result_valid,
    input wire logic [31:0] core_result,
    input wire logic core_exc_req,
    input wire logic coproc_issue,
    input wire logic [1:0] coproc_class,
    input wire logic coproc_is_fp,
    input wire logic coproc_fields_are_regs,
    input wire logic coproc_flush,
    input wire logic coproc_done,
    input wire logic [31:0] coproc_result,
    input wire logic coproc_exception
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****************
    // class behaviour
    // ****************
    a_auto_no_stall: assert property (
        coproc_issue && coproc_class == 2'h0 |-> !core_stall ##1 !core_stall)
        else $error("autonomous issue stalled");
    a_nonauto_stall: assert property (
        coproc_issue && coproc_class != 2'h0 |-> core_stall
        && (core_irq_hold == (coproc_class == 2'h1))) else $error("stall or hold wrong");
    a_stall_holds: assert property (
        core_stall && !coproc_done && !coproc_exception && !core_abort |=> core_stall)
        else $error("stall dropped early");
    a_done_result: assert property (
        core_stall && coproc_done |=> core_result_valid && !core_stall
        && core_result == $past(coproc_result)) else $error("result not returned");
    a_abort_flush: assert property (
        core_stall && !core_irq_hold && core_abort && !coproc_done && !coproc_exception
        |=> coproc_flush && !core_stall) else $error("abort not flushed");
    a_block_no_abort: assert property (
        core_irq_hold && core_abort && !coproc_done && !coproc_exception
        |=> core_stall && !coproc_flush) else $error("blocking op aborted");
    a_fp_regs: assert property (
        coproc_issue && coproc_is_fp |-> coproc_class == 2'h2 && coproc_fields_are_regs)
        else $error("float issue wrong");
    a_exc_flush: assert property (
        core_exc_req |-> coproc_flush && !core_stall && $past(coproc_exception))
        else $error("exception without flush");
    c_result: cover property (core_result_valid);
    c_abort: cover property (coproc_flush && !core_exc_req);
    c_exc: cover property (core_exc_req);
endmodule
bind cidc_decode_top cidc_decode_asserts cidc_decode_asserts_i (.*);
`default_nettype wire

/* testbench/cidc_fabric_model.sv */
// fabric coprocessor model answering issued instructions
`default_nettype none
module cidc_fabric_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic coproc_issue,
    input wire logic [31:0] coproc_instr,
    input wire logic coproc_flush,
    input wire logic [1:0] mode,
    output logic coproc_done,
    output logic [31:0] coproc_result,
    output logic coproc_exception
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // behaviour
    // ****************
    // mode 0 prompt done, 1 exception, 2 slow done after eight cycles
    int wait_r = 0;
    logic busy_r = 1'b0;
    logic [31:0] instr_r = 32'h0;
    initial {coproc_done, coproc_exception, coproc_result} = '0;
    always @(posedge pclk) begin
        coproc_done <= 1'b0;
        coproc_exception <= 1'b0;
        // result lines toggle every cycle but the done cycle so a value sampled one cycle late never matches
        coproc_result <= ~coproc_result;
        if (!presetn || coproc_flush)
            busy_r <= 1'b0;
        else if (coproc_issue) begin
            busy_r <= 1'b1;
            instr_r <= coproc_instr;
            wait_r <= mode == 2'h2 ? 8 : $urandom_range(0, 3);
        end else if (busy_r && wait_r > 0)
            wait_r <= wait_r - 1;
        else if (busy_r) begin
            busy_r <= 1'b0;
            coproc_done <= mode != 2'h1;
            coproc_exception <= mode == 2'h1;
            coproc_result <= instr_r ^ 32'h5a5a_5a5a;
        end
    end
endmodule
`default_nettype wire

/* testbench/test_cidc_decode_top.sv */
// self-checking bench for the coprocessor decode front end
`default_nettype none
module test_cidc_decode_top
    import cidc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, core_instr = 32'h0;
    logic core_issue = 1'b0, core_abort = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [31:0] prdata, core_result, core_exc_vector, coproc_instr, coproc_result;
    logic pready, pslverr, irq, core_ready, core_stall, core_irq_hold, core_illegal;
    logic core_result_valid, core_exc_req, coproc_issue, coproc_is_fp, coproc_sets_cr;
    logic coproc_fields_are_regs, coproc_custom_hit, coproc_flush, coproc_done;
    logic coproc_exception;
    logic [1:0] coproc_class;
    logic [2:0] coproc_custom_idx;
    logic [32:0] exp_q[$];
    int mismatches = 0, total_checks = 0, cycles = 0, n_ill = 0, n_fl = 0, n_exc = 0;
    int n_stall = 0, n_hold = 0;
    always #2.5 pclk = ~pclk;
    cidc_decode_top cidc_decode_top_i (.*);
    cidc_fabric_model cidc_fabric_model_i (.*);
    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // abort lands while a slow instruction still waits
    task automatic issue(input logic [31:0] i, input logic [1:0] m);
        mode <= m;
        core_issue <= 1'b1;
        core_instr <= i;
        do @(posedge pclk); while (core_ready !== 1'b1);
        core_issue <= 1'b0;
        if (m == 2'h2) begin
            repeat (4) @(posedge pclk);
            core_abort <= 1'b1;
            @(posedge pclk);
            core_abort <= 1'b0;
        end
        do @(posedge pclk); while (core_ready !== 1'b1);
        @(posedge pclk);
    endtask
    // ****************
    // monitor and sequence
    // ****************
    always @(posedge pclk) begin
        n_ill += core_illegal;
        n_fl += coproc_flush;
        n_exc += core_exc_req;
        n_stall += core_stall;
        n_hold += core_irq_hold;
        if (pready === 1'b1 && pwrite === 1'b0 || core_result_valid === 1'b1)
            chk(pready ? {pslverr, prdata} : {1'b0, core_result}, exp_q.pop_front());
    end
    always @(posedge pclk)
        if (++cycles > 5000) begin
            mismatches++;
            close_out();
        end
    initial begin
        int b;
        logic [31:0] fp;
        void'($urandom(32'h19ed122c));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(core_exc_vector, EXC_VECTOR);
        rd(ADDR_MSC, {1'b0, MSC_RESET | 32'h0004_0040});
        rd(8'hfc, {1'b1, 32'h0});
        b = n_ill;
        issue(32'h0000_0001, 2'h0);
        chk(n_ill - b, 1);
        apb(1'b1, ADDR_MSC, 32'h0090_1000);
        rd(ADDR_MSC, {1'b0, 32'h0094_1040});
        apb(1'b1, ADDR_MASK, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'hf);
        b = n_ill;
        issue(32'h0, 2'h0);
        chk(n_ill - b, 1);
        chk(irq, 1'b0);
        apb(1'b1, ADDR_MASK, 32'h2);
        chk(irq, 1'b1);
        apb(1'b1, ADDR_STATUS, 32'h2);
        chk(irq, 1'b0);
        $display("test setup and irq done");
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, ADDR_CTRL, 32'(c));
            fp = {21'h0, 11'($urandom_range(1, 2047))};
            if (c != 0)
                exp_q.push_back({1'b0, fp ^ 32'h5a5a_5a5a});
            b = n_stall;
            n_hold = 0;
            issue(fp, c == 1 ? 2'h2 : 2'h0);
            chk(n_stall > b, c != 0);
            chk(n_hold > 0, c == 1);
        end
        $display("test classes done");
        for (int k = 0; k < 2; k++) begin
            fp = {k ? OP_PRIM_FP_DOUBLE : OP_PRIM_FP_SINGLE, 26'($urandom)};
            exp_q.push_back({1'b0, fp ^ 32'h5a5a_5a5a});
            issue(fp, 2'h0);
        end
        b = n_exc;
        issue(fp, 2'h1);
        chk(n_exc - b, 1);
        b = n_fl;
        issue(fp, 2'h2);
        chk(n_fl - b, 1);
        exp_q.push_back({1'b0, fp ^ 32'h5a5a_5a5a});
        issue(fp, 2'h0);
        apb(1'b1, 8'h3c, 32'h0002_1184);
        rd(8'h3c, {1'b0, 32'h0002_1184});
        issue(32'h1000_0046, 2'h0);
        chk({coproc_custom_hit, coproc_sets_cr, coproc_custom_idx}, 5'h1f);
        repeat (4) @(posedge pclk);
        chk(exp_q.size(), 0);
        $display("test float done");
        close_out();
    end
endmodule
`default_nettype wire
